// ==== core/wwd_core.sv ====
// windowed watchdog with apb registers, one instance per cpu
`timescale 1ns/1ns
module wwd_core import wwd_pkg::*; (
	// clock, reset, enable
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        por_n,
	input  wire logic        ce,
	// watchdog oscillator pin
	input  wire logic        watchdog_oscillator,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// events
	output logic             irq,
	output logic             chip_reset_req
);
	wwd_tick_if tk ();

	// each instance owns its counter and configuration
	wwd_prescale u_pre (
		.clk     (clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.osc_in  (watchdog_oscillator),
		.tk      (tk.src)
	);

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'h0) && (a <= OFS_MASK);
	endfunction : mapped

	// configuration registers
	logic [3:0]        mode_q, mode_d;
	logic [CNT_W-1:0]  tmo_q, tmo_d;
	logic [CNT_W-1:0]  warn_q, warn_d;
	logic [CNT_W-1:0]  win_q, win_d;
	logic [ST_W-1:0]   mask_q, mask_d;
	// down counter and pending reload
	logic [CNT_W-1:0]  cnt_q, cnt_d;
	logic              pend_q, pend_d;
	// feed sequence
	wwd_feed_t         feed_q, feed_d;
	// status and event outputs
	logic [ST_W-2:0]   st_q, st_d;
	logic              rflag_q, rflag_d;
	logic              irq_q, irq_d;
	logic              crst_q, crst_d;
	// bus answer
	logic              ready_q, ready_d;
	logic              err_q, err_d;
	logic [31:0]       rdata_q, rdata_d;
	// glue between the groups
	logic              wr, setup, fire, wd_ev;
	logic              bad_feed, key_bad, win_bad, feed_ok;
	logic              tmo_ev, warn_ev;
	logic [ST_W-1:0]   st_all, st_nxt, ev, clr;
	logic [31:0]       rd;

	// bus decode: zero wait states, the answer is registered one cycle after setup
	always_comb begin
		setup = psel & ~penable;
		wr    = psel & penable & ready_q & pwrite & ~err_q;
		unique case (paddr)
			OFS_MODE:    rd = {28'h0000000, mode_q};
			OFS_TIMEOUT: rd = {8'h00, tmo_q};
			OFS_COUNT:   rd = {8'h00, cnt_q};
			OFS_WARN:    rd = {8'h00, warn_q};
			OFS_WINDOW:  rd = {8'h00, win_q};
			OFS_STATUS:  rd = {28'h0000000, st_all};
			OFS_MASK:    rd = {28'h0000000, mask_q};
			default:     rd = RDATA_ZERO;
		endcase
		ready_d = setup;
		err_d   = setup & ~mapped(paddr);
		// read data is captured at setup so it stands through the access phase
		rdata_d = (setup & ~pwrite) ? rd : rdata_q;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ready_q <= 1'b0;
			err_q   <= 1'b0;
			rdata_q <= RDATA_ZERO;
		end else if (ce) begin
			ready_q <= ready_d;
			err_q   <= err_d;
			rdata_q <= rdata_d;
		end
	end

	always_comb begin
		mode_d = mode_q;
		tmo_d  = tmo_q;
		warn_d = warn_q;
		win_d  = win_q;
		mask_d = mask_q;
		if (wr) begin
			unique case (paddr)
				OFS_MODE: begin
					mode_d          = pwdata[3:0];
					mode_d[MODE_EN] = mode_q[MODE_EN] | pwdata[MODE_EN];
				end
				OFS_TIMEOUT: begin
					tmo_d = (pwdata[CNT_W-1:0] < TIMEOUT_MIN) ? TIMEOUT_MIN
						: pwdata[CNT_W-1:0];
				end
				OFS_WARN: begin
					warn_d = pwdata[CNT_W-1:0];
				end
				OFS_WINDOW: begin
					win_d = pwdata[CNT_W-1:0];
				end
				OFS_MASK: begin
					mask_d = pwdata[ST_W-1:0];
				end
				default: begin
				end
			endcase
		end
		// a bite or a bad feed drops the enable, software alone never can
		if (wd_ev) begin
			mode_d[MODE_EN] = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_q <= MODE_RST;
			tmo_q  <= TIMEOUT_RST;
			warn_q <= WARN_RST;
			win_q  <= WINDOW_RST;
			mask_q <= 4'h0;
		end else if (ce) begin
			mode_q <= mode_d;
			tmo_q  <= tmo_d;
			warn_q <= warn_d;
			win_q  <= win_d;
			mask_q <= mask_d;
		end
	end

	always_comb begin
		feed_d  = feed_q;
		key_bad = 1'b0;
		win_bad = 1'b0;
		feed_ok = 1'b0;
		if (wr && paddr == OFS_FEED) begin
			unique case (feed_q)
				WWD_FEED_IDLE: begin
					// a stray first write is ignored rather than punished
					if (pwdata[7:0] == FEED_KEY1) begin
						feed_d = WWD_FEED_ARMED;
					end
				end
				WWD_FEED_ARMED: begin
					feed_d = WWD_FEED_IDLE;
					if (pwdata[7:0] != FEED_KEY2) begin
						key_bad = mode_q[MODE_EN];
					end else if (mode_q[MODE_WIN_EN] && mode_q[MODE_EN]
						&& cnt_q > win_q) begin
						win_bad = 1'b1;
					end else begin
						feed_ok = 1'b1;
					end
				end
			endcase
		end
		bad_feed = key_bad | win_bad;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			feed_q <= WWD_FEED_IDLE;
		end else if (ce) begin
			feed_q <= feed_d;
		end
	end

	always_comb begin
		cnt_d   = cnt_q;
		pend_d  = pend_q | feed_ok;
		tmo_ev  = 1'b0;
		warn_ev = 1'b0;
		if (tk.tick) begin
			if (pend_q || !mode_q[MODE_EN]) begin
				// a feed lands on the next tick, so the counter only moves in one domain
				cnt_d  = tmo_q;
				pend_d = 1'b0;
			end else if (cnt_q == 24'h000000) begin
				tmo_ev = 1'b1;
				cnt_d  = tmo_q;
			end else begin
				cnt_d   = cnt_q - 24'h000001;
				warn_ev = mode_q[MODE_WARN_EN] && (cnt_d == warn_q);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q  <= TIMEOUT_RST;
			pend_q <= 1'b0;
		end else if (ce) begin
			cnt_q  <= cnt_d;
			pend_q <= pend_d;
		end
	end

	// events gathered into the status layout
	always_comb begin
		st_all          = {rflag_q, st_q};
		wd_ev           = tmo_ev | bad_feed;
		fire            = wd_ev & mode_q[MODE_RST_EN];
		ev              = 4'h0;
		ev[ST_TIMEOUT]  = tmo_ev;
		ev[ST_WARN]     = warn_ev;
		ev[ST_FEED_ERR] = bad_feed;
		ev[ST_WD_RESET] = fire;
		clr             = 4'h0;
		if (wr && paddr == OFS_STATUS) begin
			clr = pwdata[ST_W-1:0];
		end
	end

	// one sticky bit per event; the set wins over a write-one clear in the same cycle
	for (genvar i = 0; i < ST_W; i++) begin : g_sticky
		assign st_nxt[i] = (st_all[i] & ~clr[i]) | ev[i];
	end

	always_comb begin
		st_d    = st_nxt[ST_W-2:0];
		rflag_d = st_nxt[ST_WD_RESET];
		crst_d  = fire;
		irq_d   = |(st_nxt & mask_d);
	end

	// reset flag survives the watchdog's own reset, only power-on or a write-one clear clears it
	always_ff @(posedge clk) begin
		if (!por_n) begin
			rflag_q <= 1'b0;
		end else if (ce) begin
			rflag_q <= rflag_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q   <= 3'h0;
			irq_q  <= 1'b0;
			crst_q <= 1'b0;
		end else if (ce) begin
			st_q   <= st_d;
			irq_q  <= irq_d;
			crst_q <= crst_d;
		end
	end

	assign pready         = ready_q;
	assign prdata         = rdata_q;
	assign pslverr        = err_q;
	assign irq            = irq_q;
	assign chip_reset_req = crst_q;
endmodule : wwd_core

// ==== pkg/wwd_pkg.sv ====
// constants for the windowed watchdog
package wwd_pkg;
	localparam logic [7:0]  OFS_MODE      = 8'h00;
	localparam logic [7:0]  OFS_TIMEOUT   = 8'h04;
	localparam logic [7:0]  OFS_FEED      = 8'h08;
	localparam logic [7:0]  OFS_COUNT     = 8'h0C;
	localparam logic [7:0]  OFS_WARN      = 8'h10;
	localparam logic [7:0]  OFS_WINDOW    = 8'h14;
	localparam logic [7:0]  OFS_STATUS    = 8'h18;
	localparam logic [7:0]  OFS_MASK      = 8'h1C;
	localparam int          CNT_W         = 24;
	localparam int          ST_W          = 4;
	localparam int          MODE_EN       = 0;
	localparam int          MODE_RST_EN   = 1;
	localparam int          MODE_WIN_EN   = 2;
	localparam int          MODE_WARN_EN  = 3;
	localparam int          ST_TIMEOUT    = 0;
	localparam int          ST_WARN       = 1;
	localparam int          ST_FEED_ERR   = 2;
	localparam int          ST_WD_RESET   = 3;
	localparam logic [7:0]  FEED_KEY1     = 8'hAA;
	localparam logic [7:0]  FEED_KEY2     = 8'h55;
	localparam logic [23:0] TIMEOUT_MIN   = 24'h0000FF;
	localparam logic [23:0] TIMEOUT_RST   = 24'hFFFFFF;
	localparam logic [23:0] WINDOW_RST    = 24'hFFFFFF;
	localparam logic [23:0] WARN_RST      = 24'h000000;
	localparam logic [3:0]  MODE_RST      = 4'h0;
	localparam logic [1:0]  PRESCALE_LAST = 2'h3;
	localparam logic [31:0] RDATA_ZERO    = 32'h00000000;
	typedef enum logic [0:0] {
		WWD_FEED_IDLE = 1'b0,
		WWD_FEED_ARMED = 1'b1
	} wwd_feed_t;
endpackage : wwd_pkg

// ==== pkg/wwd_tick_if.sv ====
// count tick carried from the prescaler to the watchdog core
`timescale 1ns/1ns
interface wwd_tick_if;
	logic tick;
	modport src (output tick);
	modport dst (input tick);
endinterface : wwd_tick_if

// ==== core/wwd_prescale.sv ====
// oscillator synchroniser and divide-by-four prescaler
`timescale 1ns/1ns
module wwd_prescale import wwd_pkg::*; (
	// clock and control
	input  wire logic     clk,
	input  wire logic     rst_n,
	input  wire logic     ce,
	// oscillator pin
	input  wire logic     osc_in,
	// tick out
	wwd_tick_if.src       tk
);
	logic [2:0] sync_q, sync_d;
	logic [1:0] div_q, div_d;
	logic       tick_q, tick_d;
	logic       rise;

	// only the second and third stages are looked at, a rise is second stage high with third stage low
	always_comb begin
		sync_d = {sync_q[1:0], osc_in};
		rise   = sync_q[1] & ~sync_q[2];
		div_d  = div_q;
		tick_d = 1'b0;
		if (rise) begin
			div_d  = div_q + 2'h1;
			tick_d = (div_q == PRESCALE_LAST);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync_q <= 3'h0;
			div_q  <= 2'h0;
			tick_q <= 1'b0;
		end else if (ce) begin
			sync_q <= sync_d;
			div_q  <= div_d;
			tick_q <= tick_d;
		end
	end

	assign tk.tick = tick_q;
endmodule : wwd_prescale

// ==== testbench/wwd_monitor.sv ====
// port checker for the windowed watchdog
`timescale 1ns/1ns
module wwd_monitor (
	// clocking
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        por_n,
	input wire logic        ce,
	input wire logic        watchdog_oscillator,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// events
	input wire logic        irq,
	input wire logic        chip_reset_req
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire logic setup = psel && !penable && ce;
	bus_answer_a: assert property (setup |=> pready)
		else $error("no answer after setup");
	one_beat_a: assert property (pready && ce |=> !pready)
		else $error("pready held");
	idle_quiet_a: assert property (!psel && ce |=> !pready)
		else $error("pready without request");
	err_beat_a: assert property (pslverr |-> pready)
		else $error("pslverr outside access");
	unmapped_err_a: assert property (setup && (paddr > 8'h1C || paddr[1:0] != 2'h0) |=> pslverr)
		else $error("unmapped address accepted");
	err_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h00000000)
		else $error("unmapped read not zero");
	upper_zero_a: assert property (pready |-> prdata[31:24] == 8'h00)
		else $error("bits above counter width set");
	reset_pulse_a: assert property (chip_reset_req && ce |=> !chip_reset_req)
		else $error("reset request longer than one cycle");
	quiet_reset_a: assert property (disable iff (1'b0) !rst_n |=> !pready && !irq && !chip_reset_req)
		else $error("outputs active after reset");
endmodule : wwd_monitor
bind wwd_core wwd_monitor mon (.clk(clk), .rst_n(rst_n), .por_n(por_n), .ce(ce),
	.watchdog_oscillator(watchdog_oscillator), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
	.pslverr(pslverr), .irq(irq), .chip_reset_req(chip_reset_req));

// ==== testbench/tb.sv ====
// self-checking bench for the windowed watchdog
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("mismatch %s exp %h got %h", n, e, g); end end
module tb import wwd_pkg::*;;
	logic        clk, rst_n, por_n, ce, psel, penable, pwrite, pready, pslverr, irq, crq, er;
	logic        osc = 1'b0;
	logic [7:0]  paddr;
	logic [1:0]  oc = 2'h0;
	logic [31:0] pwdata, prdata, rd, v;
	int          n_fail = 0, n_checks = 0, n_rst = 0, cyc = 0;
	wwd_core dut (.clk(clk), .rst_n(rst_n), .por_n(por_n), .ce(ce), .watchdog_oscillator(osc),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq), .chip_reset_req(crq));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic give_verdict();
		if (n_fail == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict
	// oscillator runs at a quarter of clk, so one count tick is sixteen cycles
	always @(posedge clk) begin
		oc <= oc + 2'h1;
		osc <= oc[1];
		n_rst <= n_rst + int'(crq === 1'b1);
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_fail++;
			give_verdict();
		end
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic chk_reg(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(n, e, rd)
	endtask : chk_reg
	task automatic feed(input logic [31:0] k);
		apb(1'b1, OFS_FEED, 32'hAA);
		apb(1'b1, OFS_FEED, k);
	endtask : feed
	function automatic logic [31:0] exp_to(input logic [31:0] x);
		return (x[23:0] < TIMEOUT_MIN) ? {8'h00, TIMEOUT_MIN} : {8'h00, x[23:0]};
	endfunction : exp_to
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		ce = 1'b1;
		rst_n = 1'b0;
		por_n = 1'b0;
		void'($urandom(32'h4C72));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		por_n <= 1'b1;
		chk_reg("mode", OFS_MODE, {28'h0, MODE_RST});
		chk_reg("window", OFS_WINDOW, {8'h00, WINDOW_RST});
		chk_reg("status", OFS_STATUS, 32'h0);
		apb(1'b1, OFS_COUNT, 32'h0);
		chk_reg("count", OFS_COUNT, {8'h00, TIMEOUT_RST});
		apb(1'b0, 8'h22, 32'h0);
		`CHK("slverr", 1'b1, er)
		for (int i = 0; i < 6; i++) begin
			v = (i < 3) ? $urandom_range(255) : $urandom;
			apb(1'b1, OFS_WARN, v);
			chk_reg("warn", OFS_WARN, {8'h00, v[23:0]});
			apb(1'b1, OFS_TIMEOUT, v);
			chk_reg("timeout", OFS_TIMEOUT, exp_to(v));
		end
		apb(1'b1, OFS_TIMEOUT, 32'hFF);
		apb(1'b1, OFS_WARN, 32'h80);
		apb(1'b1, OFS_MASK, 32'hF);
		apb(1'b1, OFS_MODE, 32'hB);
		apb(1'b1, OFS_MODE, 32'hA);
		chk_reg("enable", OFS_MODE, 32'hB);
		repeat (3) begin
			repeat (1500) @(posedge clk);
			feed(32'h55);
		end
		`CHK("fed", 0, n_rst)
		repeat (6000) @(posedge clk);
		`CHK("bite", 1, n_rst)
		chk_reg("status", OFS_STATUS, 32'hB);
		`CHK("irq", 1'b1, irq)
		chk_reg("disable", OFS_MODE, 32'hA);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		chk_reg("flag", OFS_STATUS, 32'h8);
		apb(1'b1, OFS_STATUS, 32'hF);
		chk_reg("cleared", OFS_STATUS, 32'h0);
		apb(1'b1, OFS_MASK, 32'hF);
		apb(1'b1, OFS_MODE, 32'h3);
		feed(32'h12);
		repeat (8) @(posedge clk);
		`CHK("bad feed", 2, n_rst)
		chk_reg("feed err", OFS_STATUS, 32'hC);
		apb(1'b1, OFS_STATUS, 32'hF);
		apb(1'b1, OFS_WINDOW, 32'h10);
		apb(1'b1, OFS_MODE, 32'h5);
		feed(32'h55);
		chk_reg("early", OFS_STATUS, 32'h4);
		`CHK("irq", 1'b1, irq)
		apb(1'b1, OFS_MASK, 32'h0);
		repeat (2) @(posedge clk);
		`CHK("masked", 1'b0, irq)
		`CHK("no reset", 2, n_rst)
		give_verdict();
	end
endmodule : tb
